// ===== design/acc_top.sv
`timescale 1ns/1ps
module acc_top
  import acc_pkg::*;
(
  input wire logic clk, // peripheral clock, 40 MHz
  input wire logic reset_n, // asynchronous reset, active low
  input wire acc_sfr_req_t sfr, // special function register access
  output logic [7:0] sfr_rdata, // read data, valid the cycle after rd
  input wire logic irq_enable_in, // converter interrupt enable bit
  input wire logic comparator_in, // comparator output, asynchronous
  output acc_analog_t analog, // controls for the analog section
  output logic conversion_irq, // interrupt request, level
  output logic cpu_freeze // halts CPU instruction execution
);

  typedef struct packed {
    acc_ctrl_t ctrl;
    logic [ACC_DIV_W-1:0] clkdiv;
    logic [7:0] res_high;
    logic [1:0] res_low;
    acc_phase_t phase;
    logic [3:0] periods;
    logic sample;
    logic cmp_meta;
    logic cmp_sync;
    logic irq;
    logic freeze_out;
    logic [7:0] rdata;
  } acc_top_state_t;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n_s;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n_s <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  acc_top_state_t s;
  acc_top_state_t n;
  logic div_tick;
  logic start_ok;
  logic done_w;
  logic abort_w;
  logic sar_decide;
  logic wr_ctrl;
  logic wr_clkdiv;
  logic [ACC_RES_W-1:0] sar_code;
  logic [ACC_RES_W-1:0] final_code;

  acc_clk_div u_div (
    .clk(clk),
    .rst_n(rst_n_s),
    .restart(start_ok),
    .divide(s.clkdiv),
    .tick(div_tick)
  );

  acc_sar u_sar (
    .clk(clk),
    .rst_n(rst_n_s),
    .load(start_ok),
    .decide(sar_decide),
    .keep(s.cmp_sync),
    .code(sar_code)
  );

  // ----------------------------------------------------------------
  // Control, sequencing and register file
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    wr_ctrl = sfr.wr && (sfr.addr == ACC_ADDR_CTRL);
    wr_clkdiv = sfr.wr && (sfr.addr == ACC_ADDR_CLKDIV);
    // The last decision is taken from the synchronised comparator bit, not from the SAR register.
    final_code = {sar_code[ACC_RES_W-1:1], s.cmp_sync};
    start_ok = wr_ctrl && sfr.wdata[ACC_BIT_START]
      && sfr.wdata[ACC_BIT_ENABLE] && !s.ctrl.busy;
    done_w = (s.phase == ACC_DECIDE) && div_tick
      && (s.periods == ACC_CONV_LAST);
    sar_decide = (s.phase == ACC_DECIDE) && div_tick;

    n.cmp_meta = comparator_in;
    n.cmp_sync = s.cmp_meta;

    if (wr_clkdiv) begin
      n.clkdiv = sfr.wdata[ACC_DIV_W-1:0];
    end
    if (wr_ctrl) begin
      n.ctrl.chan = sfr.wdata[ACC_BIT_CHAN];
      n.ctrl.enable = sfr.wdata[ACC_BIT_ENABLE];
      n.ctrl.freeze = sfr.wdata[ACC_BIT_FREEZE];
      n.ctrl.done = s.ctrl.done & sfr.wdata[ACC_BIT_DONE];
    end
    abort_w = s.ctrl.busy && !n.ctrl.enable && !done_w;

    if (start_ok) begin
      n.ctrl.busy = 1'b1;
      n.phase = ACC_SAMPLE;
      n.sample = 1'b1;
      n.periods = 4'h0;
    end else begin
      unique case (s.phase)
        ACC_IDLE: begin
        end
        ACC_SAMPLE: begin
          if (div_tick) begin
            n.phase = ACC_DECIDE;
            n.sample = 1'b0;
            n.periods = 4'h1;
          end
        end
        ACC_DECIDE: begin
          if (div_tick && !done_w) begin
            n.periods = s.periods + 4'h1;
          end
        end
      endcase
    end

    if (done_w) begin
      n.res_high = final_code[ACC_RES_W-1:2];
      n.res_low = final_code[1:0];
      n.ctrl.done = 1'b1;
      n.ctrl.busy = 1'b0;
      n.ctrl.freeze = 1'b0;
      n.phase = ACC_IDLE;
    end
    if (abort_w) begin
      n.ctrl.busy = 1'b0;
      n.ctrl.freeze = 1'b0;
      n.phase = ACC_IDLE;
      n.sample = 1'b0;
    end

    // Only the CPU is held; divider and sequencing run on.
    n.freeze_out = n.ctrl.freeze && n.ctrl.busy;
    // The level stays up while frozen, so the request remains pending.
    n.irq = n.ctrl.done && irq_enable_in;

    n.rdata = ACC_BYTE_ZERO;
    if (sfr.rd) begin
      unique case (sfr.addr)
        ACC_ADDR_CLKDIV: n.rdata = {3'b000, s.clkdiv};
        ACC_ADDR_CTRL: n.rdata = acc_ctrl_byte(s.ctrl);
        ACC_ADDR_RES_LOW: n.rdata = {6'b00_0000, s.res_low};
        ACC_ADDR_RES_HIGH: n.rdata = s.res_high;
        default: n.rdata = ACC_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfr_rdata = s.rdata;
  assign conversion_irq = s.irq;
  assign cpu_freeze = s.freeze_out;
  assign analog.enable = s.ctrl.enable;
  assign analog.select_first = s.ctrl.chan;
  assign analog.sample = s.sample;
  assign analog.dac_code = sar_code;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [3:0] ticks_seen;

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ticks_seen <= 4'h0;
    end else if (start_ok) begin
      ticks_seen <= 4'h0;
    end else if (s.ctrl.busy && div_tick) begin
      ticks_seen <= ticks_seen + 4'h1;
    end
  end

  // Cycles since the last conversion-clock tick, for the period check.
  logic [ACC_CNT_W-1:0] gap_q;
  logic div_moved_q;

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      gap_q <= '0;
      div_moved_q <= 1'b0;
    end else begin
      if (start_ok || div_tick) begin
        gap_q <= '0;
      end else begin
        gap_q <= gap_q + 6'h01;
      end
      if (start_ok) begin
        div_moved_q <= 1'b0;
      end else if (wr_clkdiv) begin
        div_moved_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n_s);

  a_start_sets_busy: assert property (
    start_ok |=> s.ctrl.busy && (s.phase == ACC_SAMPLE))
    else $error("start write did not set the busy bit");

  a_conv_eleven_periods: assert property (
    done_w |-> (ticks_seen == ACC_CONV_LAST) && div_tick)
    else $error("conversion did not take eleven periods");

  a_done_and_busy: assert property (
    done_w |=> s.ctrl.done && !s.ctrl.busy)
    else $error("completion did not set done and clear busy");

  a_done_clear_by_sw: assert property (
    $fell(s.ctrl.done) |-> $past(wr_ctrl) && !$past(sfr.wdata[ACC_BIT_DONE]))
    else $error("done flag fell without a software clear");

  a_irq_follows_flag: assert property (
    conversion_irq == (s.ctrl.done && $past(irq_enable_in)))
    else $error("interrupt request does not match flag and enable");

  a_result_layout: assert property (
    done_w |=> (s.res_high == $past(final_code[9:2]))
      && (s.res_low == $past(final_code[1:0])))
    else $error("result bits placed wrongly");

  a_results_read_only: assert property (
    (sfr.wr && !done_w) |=> $stable(s.res_high) && $stable(s.res_low))
    else $error("write changed a result register");

  a_freeze_with_conv: assert property (
    (start_ok && sfr.wdata[ACC_BIT_FREEZE]) |=> cpu_freeze throughout
      (s.ctrl.busy [*2]))
    else $error("CPU not held during a frozen conversion");

  a_freeze_released: assert property (
    done_w |=> !cpu_freeze && !s.ctrl.freeze)
    else $error("freeze not released at end of conversion");

  a_standby_idle: assert property (
    !n.ctrl.enable |=> !s.ctrl.busy && !analog.enable)
    else $error("converter busy while disabled");

  a_no_restart: assert property (
    (wr_ctrl && s.ctrl.busy && sfr.wdata[ACC_BIT_ENABLE] && !done_w)
      |=> s.ctrl.busy && !$rose(s.sample)
      && (s.periods >= $past(s.periods)))
    else $error("start during a conversion disturbed it");

  a_channel_follows: assert property (
    wr_ctrl |=> (analog.select_first == $past(sfr.wdata[ACC_BIT_CHAN])))
    else $error("channel select does not follow the control bit");

  a_busy_readback: assert property (
    (sfr.rd && (sfr.addr == ACC_ADDR_CTRL))
      |=> (sfr_rdata[ACC_BIT_START] == $past(s.ctrl.busy)))
    else $error("start bit does not read back the busy state");

  a_low_bits_zero: assert property (
    (sfr.rd && (sfr.addr == ACC_ADDR_RES_LOW))
      |=> (sfr_rdata[7:2] == 6'h00))
    else $error("low result register upper bits not zero");

  a_ctrl_reserved: assert property (
    (sfr.rd && (sfr.addr == ACC_ADDR_CTRL))
      |=> !sfr_rdata[7] && (sfr_rdata[2:1] == 2'b00))
    else $error("control reserved bits not zero");

  a_div_reserved: assert property (
    (sfr.rd && (sfr.addr == ACC_ADDR_CLKDIV))
      |=> (sfr_rdata[7:5] == 3'b000))
    else $error("divider reserved bits not zero");

  a_divider_period: assert property (
    (div_tick && (s.phase == ACC_DECIDE) && !div_moved_q)
      |-> (gap_q == acc_div_ratio(s.clkdiv) - 6'h01))
    else $error("conversion clock period does not match divider");

  a_sample_first: assert property (
    start_ok |=> analog.sample && (analog.dac_code == ACC_SAR_MSB))
    else $error("conversion did not begin with sampling and MSB trial");

  a_frozen_runs_on: assert property (
    (cpu_freeze && div_tick && (s.phase == ACC_DECIDE) && !done_w)
      |=> (s.periods == $past(s.periods) + 4'h1))
    else $error("sequencing stalled while the CPU was frozen");

  c_conversion_done: cover property (done_w);
  c_abort: cover property (abort_w);
  c_frozen_conv: cover property (cpu_freeze ##1 done_w ##1 !cpu_freeze);
  c_irq_raised: cover property ($rose(conversion_irq));
  c_restart_attempt: cover property (wr_ctrl && s.ctrl.busy);

endmodule

// ===== design/acc_pkg.sv
// Contract
// - Channel select 1 converts the first input, 0 converts the second.
// - Writing start begins a conversion; start reads 1 until it ends.
// - The result is ready eleven conversion-clock periods after start.
// - Completion sets the done flag and clears start together.
// - Only hardware sets the done flag; software writes 0 to clear.
// - Interrupt request is done flag AND the converter interrupt enable.
// - Result bits 9..2 go high register, bits 1..0 go low register.
// - Result registers ignore writes; low register bits 7..2 read 0.
// - Freeze bit plus launched conversion halts the CPU until the end.
// - Hardware clears the freeze bit at the end, releasing the CPU.
// - Freeze stops only the CPU; peripherals and clocks keep running.
// - Interrupts during freeze stay pending and are served afterwards.
// - Enable 1 runs the converter; 0 keeps it in standby.
// - Conversion clock is peripheral clock over a 5-bit divider; 0 is 32.
// - Reserved bits read 0; software never writes them as 1.
// - Reset clears control and both result registers.
package acc_pkg;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_ADDR_CLKDIV = 8'hf2;
  localparam logic [7:0] ACC_ADDR_CTRL = 8'hf3;
  localparam logic [7:0] ACC_ADDR_RES_LOW = 8'hf4;
  localparam logic [7:0] ACC_ADDR_RES_HIGH = 8'hf5;

  localparam int ACC_BIT_FREEZE = 6;
  localparam int ACC_BIT_ENABLE = 5;
  localparam int ACC_BIT_DONE = 4;
  localparam int ACC_BIT_START = 3;
  localparam int ACC_BIT_CHAN = 0;

  localparam int ACC_RES_W = 10;
  localparam int ACC_DIV_W = 5;
  localparam int ACC_CNT_W = 6;

  localparam logic [7:0] ACC_BYTE_ZERO = 8'h00;
  localparam logic [4:0] ACC_CLKDIV_RESET = 5'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [3:0] ACC_CONV_PERIODS = 4'hb;
  localparam logic [3:0] ACC_CONV_LAST = ACC_CONV_PERIODS - 4'h1;
  localparam logic [5:0] ACC_DIV_ZERO_RATIO = 6'h20;
  localparam logic [ACC_RES_W-1:0] ACC_SAR_MSB = 10'h200;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic freeze;
    logic enable;
    logic done;
    logic busy;
    logic chan;
  } acc_ctrl_t;

  typedef enum logic [1:0] {ACC_IDLE, ACC_SAMPLE, ACC_DECIDE} acc_phase_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acc_sfr_req_t;

  typedef struct packed {
    logic enable;
    logic select_first;
    logic sample;
    logic [ACC_RES_W-1:0] dac_code;
  } acc_analog_t;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [ACC_CNT_W-1:0] acc_div_ratio(
      input logic [ACC_DIV_W-1:0] div);
    acc_div_ratio = (div == 5'h00) ? ACC_DIV_ZERO_RATIO : {1'b0, div};
  endfunction

  function automatic logic [7:0] acc_ctrl_byte(input acc_ctrl_t c);
    logic [7:0] b;
    b = ACC_BYTE_ZERO;
    b[ACC_BIT_FREEZE] = c.freeze;
    b[ACC_BIT_ENABLE] = c.enable;
    b[ACC_BIT_DONE] = c.done;
    b[ACC_BIT_START] = c.busy;
    b[ACC_BIT_CHAN] = c.chan;
    acc_ctrl_byte = b;
  endfunction

endpackage

// ===== design/acc_clk_div.sv
`timescale 1ns/1ps
module acc_clk_div
  import acc_pkg::*;
(
  input wire logic clk, // peripheral clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic restart, // restart the period at a conversion start
  input wire logic [ACC_DIV_W-1:0] divide, // divider field
  output logic tick // one pulse per conversion-clock period
);

  typedef struct packed {
    logic [ACC_CNT_W-1:0] count;
    logic tick;
  } acc_div_state_t;

  acc_div_state_t s;
  acc_div_state_t n;
  logic [ACC_CNT_W-1:0] ratio;

  // ----------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    ratio = acc_div_ratio(divide);
    n.tick = !restart && (s.count == ratio - 6'h01);
    if (restart || n.tick) begin
      n.count = '0;
    end else begin
      n.count = s.count + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;

endmodule

// ===== design/acc_sar.sv
`timescale 1ns/1ps
module acc_sar
  import acc_pkg::*;
(
  input wire logic clk, // peripheral clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic load, // begin a new approximation
  input wire logic decide, // take one bit decision
  input wire logic keep, // comparator: input is at or above the trial level
  output logic [ACC_RES_W-1:0] code // trial code driven to the DAC
);

  typedef struct packed {
    logic [ACC_RES_W-1:0] code;
    logic [ACC_RES_W-1:0] mask;
  } acc_sar_state_t;

  acc_sar_state_t s;
  acc_sar_state_t n;

  // ----------------------------------------------------------------
  // Bit trial, most significant bit first
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    if (load) begin
      n.code = ACC_SAR_MSB;
      n.mask = ACC_SAR_MSB;
    end else if (decide && (s.mask != '0)) begin
      n.code = keep ? s.code : (s.code & ~s.mask);
      n.mask = s.mask >> 1;
      n.code = n.code | n.mask;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign code = s.code;

endmodule

// ===== verif/acc_analog_model.sv
`timescale 1ns/1ps
module acc_analog_model
  import acc_pkg::*;
(
  input wire logic clk, // peripheral clock
  input wire acc_analog_t analog, // controls from the converter
  input wire logic [ACC_RES_W-1:0] level_first, // first input level
  input wire logic [ACC_RES_W-1:0] level_second, // second input level
  output logic comparator_out // comparator result
);
  logic [ACC_RES_W-1:0] held;
  logic wobble;

  initial begin
    held = 10'h000;
    wobble = 1'b0;
  end

  // ----------------------------------------------------------------
  // Sample and hold
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    wobble <= ~wobble;
    if (analog.sample) begin
      held <= analog.select_first ? level_first : level_second;
    end
  end

  // In standby the comparator output means nothing, so it chatters.
  assign comparator_out = analog.enable ? (held >= analog.dac_code)
                                        : wobble;
endmodule

// ===== verif/tb_acc_top.sv
`timescale 1ns/1ps
module tb_acc_top
  import acc_pkg::*;
;
  logic clk;
  logic reset_n;
  acc_sfr_req_t sfr;
  logic [7:0] sfr_rdata;
  logic irq_enable_in;
  logic comparator_in;
  acc_analog_t analog;
  logic conversion_irq;
  logic cpu_freeze;
  logic [ACC_RES_W-1:0] level_first;
  logic [ACC_RES_W-1:0] level_second;
  logic [7:0] exp_q[$];
  logic pend;
  int num_errors;
  int comparisons;
  int seed;

  acc_top u_acc_top (
    .clk(clk),
    .reset_n(reset_n),
    .sfr(sfr),
    .sfr_rdata(sfr_rdata),
    .irq_enable_in(irq_enable_in),
    .comparator_in(comparator_in),
    .analog(analog),
    .conversion_irq(conversion_irq),
    .cpu_freeze(cpu_freeze)
  );

  acc_analog_model u_acc_analog_model (
    .clk(clk),
    .analog(analog),
    .level_first(level_first),
    .level_second(level_second),
    .comparator_out(comparator_in)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Compare tasks and verdict
  // ----------------------------------------------------------------
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic finish_test();
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One access; a read notes its expected byte for the monitor.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr <= '{wr: wr, rd: ~wr, addr: a, wdata: d};
    if (!wr) begin
      exp_q.push_back(d);
    end
    @(posedge clk);
    sfr <= '0;
  endtask

  // Read data stands for the one cycle after the read strobe.
  always @(negedge clk) begin
    if (pend) begin
      check_byte(sfr_rdata, exp_q.pop_front());
    end
    pend <= sfr.rd;
  end

  // ----------------------------------------------------------------
  // One conversion with its completion, result and flag handling
  // ----------------------------------------------------------------
  task automatic convert(input logic ch, input logic [4:0] dv, input logic fz);
    logic [7:0] go;
    logic [ACC_RES_W-1:0] vin;
    int n;
    int cnt;
    go = {1'b0, fz, 1'b1, 1'b0, 1'b1, 2'b00, ch};
    n = (dv == 5'h00) ? 32 : int'(dv);
    @(posedge clk);
    level_first <= 10'($random(seed));
    level_second <= 10'($random(seed));
    bus(1'b1, ACC_ADDR_CLKDIV, {3'b000, dv});
    bus(1'b0, ACC_ADDR_CLKDIV, {3'b000, dv});
    vin = ch ? level_first : level_second;
    bus(1'b1, ACC_ADDR_CTRL, go);
    #1;
    check_val(16'(analog.select_first), 16'(ch));
    check_val(16'(analog.dac_code), 16'(ACC_SAR_MSB));
    bus(1'b0, ACC_ADDR_CTRL, go);
    bus(1'b1, ACC_ADDR_CTRL, go);
    #1;
    check_val(16'(cpu_freeze), 16'(fz));
    cnt = 4;
    while (conversion_irq !== 1'b1 && cnt < 400) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    // The flag is registered one clock after the eleventh period ends.
    check_val(16'(cnt), 16'(11 * n + 1));
    if (cnt >= 400) begin
      finish_test();
    end
    check_val(16'(cpu_freeze), 16'h0000);
    bus(1'b0, ACC_ADDR_CTRL, {3'b001, 4'h8, ch});
    bus(1'b0, ACC_ADDR_RES_HIGH, vin[9:2]);
    bus(1'b0, ACC_ADDR_RES_LOW, {6'h00, vin[1:0]});
    bus(1'b1, ACC_ADDR_RES_HIGH, 8'hff);
    bus(1'b1, ACC_ADDR_RES_LOW, 8'hff);
    bus(1'b0, ACC_ADDR_RES_HIGH, vin[9:2]);
    bus(1'b0, ACC_ADDR_RES_LOW, {6'h00, vin[1:0]});
    @(posedge clk);
    irq_enable_in <= 1'b0;
    bus(1'b0, ACC_ADDR_CTRL, {3'b001, 4'h8, ch});
    #1;
    check_val(16'(conversion_irq), 16'h0000);
    @(posedge clk);
    irq_enable_in <= 1'b1;
    bus(1'b0, ACC_ADDR_CTRL, {3'b001, 4'h8, ch});
    #1;
    check_val(16'(conversion_irq), 16'h0001);
    bus(1'b1, ACC_ADDR_CTRL, {3'b001, 4'h0, ch});
    bus(1'b1, ACC_ADDR_CTRL, {3'b001, 4'h8, ch});
    bus(1'b0, ACC_ADDR_CTRL, {3'b001, 4'h0, ch});
    #1;
    check_val(16'(conversion_irq), 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] addrs [5];
    addrs = '{ACC_ADDR_CTRL, ACC_ADDR_RES_LOW, ACC_ADDR_RES_HIGH,
              ACC_ADDR_CLKDIV, 8'hf0};
    seed = 21364;
    num_errors = 0;
    comparisons = 0;
    pend = 1'b0;
    reset_n = 1'b0;
    sfr = '0;
    irq_enable_in = 1'b0;
    level_first = 10'h000;
    level_second = 10'h000;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (addrs[i]) begin
      bus(1'b0, addrs[i], 8'h00);
    end
    bus(1'b1, ACC_ADDR_CTRL, 8'h08);
    bus(1'b0, ACC_ADDR_CTRL, 8'h00);
    #1;
    check_val(16'(analog.enable), 16'h0000);
    bus(1'b1, ACC_ADDR_CTRL, 8'h20);
    #1;
    check_val(16'(analog.enable), 16'h0001);
    @(posedge clk);
    irq_enable_in <= 1'b1;
    // Give the analog section time to settle after enabling.
    repeat (20) @(posedge clk);
    convert(1'b1, 5'h04, 1'b0);
    convert(1'b0, 5'h00, 1'b0);
    convert(1'b0, 5'h05, 1'b1);
    convert(1'b1, 5'h03, 1'b1);
    // Dropping enable mid-conversion abandons it without a done flag.
    bus(1'b1, ACC_ADDR_CTRL, 8'h28);
    bus(1'b1, ACC_ADDR_CTRL, 8'h00);
    bus(1'b0, ACC_ADDR_CTRL, 8'h00);
    #1;
    check_val(16'(analog.enable), 16'h0000);
    finish_test();
  end

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    finish_test();
  end
endmodule
